// File: vectored_priority_interrupts_bench.sv
/*
  Self-checking bench of the interrupt controller: drives sources, enables
  and priorities; the CPU model acknowledges vectors.
  Assumes vpi_pkg, the controller and the CPU model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module vectored_priority_interrupts_bench;
  import vpi_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [14:0] src = 15'h0000;
  logic [2:0] comp_lo = 3'h0;
  logic breakpoint_match = 1'b0;
  logic debug_slave_mode = 1'b0;
  logic debug_host_req = 1'b0;
  logic [6:0] debug_host_id = 7'h00;
  logic [6:0] debug_own_id = 7'h15;
  logic irq_global_en = 1'b1;
  logic [14:0] irq_enable = 15'h0000;
  logic [14:0] irq_priority = 15'h0000;
  logic flag_wr = 1'b0;
  logic [7:0] flag_wr_data = 8'h00;
  logic [3:0] sw_flag_clr = 4'h0;
  logic cpu_reti = 1'b0;
  logic ack_en = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic cpu_ack, irq_req, timer0_overflow_flag, timer1_overflow_flag;
  logic breakpoint_irq, debug_port_irq;
  logic [7:0] irq_vector, ext_irq_flag_reg, took_vec, took_cnt;
  logic [13:0] shared_src_flags;
  logic [2:0] in_service, req_group;
  vpi_lvl_e irq_level, took_lvl;
  int fail_count = 0;
  int checked = 0;
  wire logic pin_group0_irq = src[0];
  wire logic timer0_ovf_evt = src[1];
  wire logic pin_group1_irq = src[2];
  wire logic timer1_ovf_evt = src[3];
  wire logic [1:0] serial0_tx_rx_flags = {1'b0, src[4]};
  wire logic timer2_overflow_flag = src[5];
  wire logic [1:0] serial2_tx_rx_flags = {src[6], 1'b0};
  wire logic i2c_master_evt = src[7];
  wire logic [1:0] low_voltage_detectors = {src[8], 1'b0};
  wire logic [3:0] comparator_flags = {src[9], comp_lo};
  wire logic [1:0] converter_pwm_flags = {1'b0, src[10]};
  wire logic watchdog_irq_flag = src[11];
  wire logic counter_array_irq = src[12];
  wire logic [3:0] serial_slave_group_flags = {1'b0, src[13], 2'b00};
  wire logic [1:0] calendar_timer3_flags = {src[14], 1'b0};

  vpi_ctrl vpi_ctrl_i (
    .clk, .resetn, .pin_group0_irq, .pin_group1_irq, .timer0_ovf_evt, .timer1_ovf_evt,
    .timer2_overflow_flag, .serial0_tx_rx_flags, .serial2_tx_rx_flags, .i2c_master_evt,
    .low_voltage_detectors, .comparator_flags, .converter_pwm_flags, .watchdog_irq_flag,
    .counter_array_irq, .serial_slave_group_flags, .calendar_timer3_flags,
    .breakpoint_match, .debug_slave_mode, .debug_host_req, .debug_host_id, .debug_own_id,
    .irq_global_en, .irq_enable, .irq_priority, .flag_wr, .flag_wr_data, .sw_flag_clr,
    .cpu_ack, .cpu_reti, .irq_req, .irq_vector, .irq_level, .timer0_overflow_flag,
    .timer1_overflow_flag, .breakpoint_irq, .debug_port_irq, .ext_irq_flag_reg,
    .shared_src_flags, .in_service, .req_group
  );
  vpi_cpu_model vpi_cpu_model_i (
    .clk, .resetn, .irq_req, .irq_vector, .irq_level, .ack_en, .ack_wait, .cpu_ack,
    .took_vec, .took_lvl, .took_cnt
  );

  always #10 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_lvl(input string name, input vpi_lvl_e exp, input vpi_lvl_e got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Waits a bounded time for the model to take one vector
  task automatic take(input logic [7:0] vec, input vpi_lvl_e lvl);
    logic [7:0] n0;
    n0 = took_cnt;
    for (int k = 0; k < 40 && took_cnt === n0; k++) @(posedge clk);
    chk("ack count", 16'(n0 + 8'h01), 16'(took_cnt));
    chk("taken vector", 16'(vec), 16'(took_vec));
    chk_lvl("taken level", lvl, took_lvl);
  endtask
  task automatic ret();
    cpu_reti <= 1'b1;
    tick(1);
    cpu_reti <= 1'b0;
    tick(1);
  endtask
  task automatic clr(input logic [3:0] m);
    sw_flag_clr <= m;
    tick(1);
    sw_flag_clr <= 4'h0;
    tick(1);
  endtask
  // The flag view is a register behind the flag, so allow two edges
  task automatic wr_flag(input logic [7:0] d);
    flag_wr <= 1'b1;
    flag_wr_data <= d;
    tick(1);
    flag_wr <= 1'b0;
    tick(2);
  endtask
  task automatic host_debug(input logic [6:0] id);
    debug_host_req <= 1'b1;
    debug_host_id <= id;
    tick(1);
    debug_host_req <= 1'b0;
    tick(2);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    tick(6000);
    fail_count++;
    test_done();
  end

  initial begin
    tick(6);
    resetn <= 1'b1;
    tick(3);
    chk("reset req", 16'h0, 16'(irq_req));
    chk("reset flags", 16'h0, 16'(ext_irq_flag_reg));
    chk("reset service", 16'h0, 16'(in_service));
    ack_en <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      ack_wait <= 4'(i % 4);
      irq_enable <= 15'h0001 << i;
      src <= 15'h0001 << i;
      tick(1);
      if (i == 1 || i == 3 || i == 7) src <= 15'h0000;
      take(8'(i * 8 + 3), VPI_LVL_LOW);
      tick(1);
      chk("service low", 16'h1, 16'(in_service));
      src <= 15'h0000;
      if (i == 1) chk("t0 flag", 16'h0, 16'(timer0_overflow_flag));
      if (i == 3) chk("t1 flag", 16'h0, 16'(timer1_overflow_flag));
      if (i == 7) begin
        chk("i2c master kept", 16'h1, 16'(ext_irq_flag_reg[0]));
        wr_flag(8'hff);
        chk("i2c master one", 16'h1, 16'(ext_irq_flag_reg[0]));
        wr_flag(8'h00);
        chk("i2c master zero", 16'h0, 16'(ext_irq_flag_reg[0]));
      end
      tick(2);
      ret();
      chk("service idle", 16'h0, 16'(in_service));
    end
    ack_en <= 1'b0;
    ack_wait <= 4'h0;
    irq_enable <= 15'h7fff;
    src <= 15'h7f75;
    tick(4);
    chk("natural first", 16'h03, 16'(irq_vector));
    chk("groups", 16'h7, 16'(req_group));
    src <= 15'h7f70;
    tick(4);
    chk("natural next", 16'h23, 16'(irq_vector));
    irq_priority <= 15'h4000;
    tick(4);
    chk("high wins", 16'h73, 16'(irq_vector));
    chk_lvl("high level", VPI_LVL_HIGH, irq_level);
    ack_en <= 1'b1;
    take(8'h73, VPI_LVL_HIGH);
    irq_priority <= 15'h4020;
    tick(4);
    chk("same level waits", 16'h0, 16'(irq_req));
    ret();
    take(8'h2b, VPI_LVL_HIGH);
    irq_priority <= 15'h0000;
    src <= 15'h7f50;
    tick(3);
    ret();
    take(8'h23, VPI_LVL_LOW);
    irq_priority <= 15'h4000;
    take(8'h73, VPI_LVL_HIGH);
    chk("nested", 16'h3, 16'(in_service));
    ack_en <= 1'b0;
    src <= 15'h0001;
    irq_priority <= 15'h0001;
    tick(3);
    ret();
    ret();
    breakpoint_match <= 1'b1;
    tick(1);
    breakpoint_match <= 1'b0;
    tick(4);
    chk("bkpt flag", 16'h1, 16'(breakpoint_irq));
    chk("bkpt vector", 16'h7b, 16'(irq_vector));
    chk_lvl("bkpt level", VPI_LVL_DEBUG, irq_level);
    debug_slave_mode <= 1'b1;
    host_debug(7'h2a);
    chk("debug id", 16'h0, 16'(debug_port_irq));
    debug_slave_mode <= 1'b0;
    host_debug(7'h15);
    chk("debug mode", 16'h0, 16'(debug_port_irq));
    debug_slave_mode <= 1'b1;
    host_debug(7'h15);
    chk("debug flag", 16'h1, 16'(debug_port_irq));
    tick(2);
    chk("debug vector", 16'h83, 16'(irq_vector));
    ack_en <= 1'b1;
    take(8'h83, VPI_LVL_DEBUG);
    tick(3);
    chk("debug nest", 16'h0, 16'(irq_req));
    chk("debug kept", 16'h1, 16'(debug_port_irq));
    clr(4'b1000);
    chk("debug clr", 16'h0, 16'(debug_port_irq));
    ret();
    take(8'h7b, VPI_LVL_DEBUG);
    clr(4'b0100);
    chk("bkpt clr", 16'h0, 16'(breakpoint_irq));
    ret();
    take(8'h03, VPI_LVL_HIGH);
    src <= 15'h0000;
    tick(3);
    ret();
    ack_en <= 1'b0;
    irq_enable <= 15'h0000;
    src <= 15'h7f75;
    tick(4);
    chk("all masked", 16'h0, 16'(irq_req));
    irq_enable <= 15'h7fff;
    irq_global_en <= 1'b0;
    tick(4);
    chk("global off", 16'h0, 16'(irq_req));
    src <= 15'h0000;
    irq_global_en <= 1'b1;
    comp_lo <= 3'b010;
    irq_enable <= 15'h0200;
    tick(4);
    chk("shared flags", 16'h0008, 16'(shared_src_flags));
    chk("shared ext", 16'h04, 16'(ext_irq_flag_reg));
    chk("shared vector", 16'h4b, 16'(irq_vector));
    wr_flag(8'h00);
    chk("ext ignore", 16'h04, 16'(ext_irq_flag_reg));
    comp_lo <= 3'b000;
    tick(4);
    chk("shared gone", 16'h0, 16'(irq_req));
    test_done();
  end
endmodule // vectored_priority_interrupts_bench
`default_nettype wire

// File: vpi_cfg.svh
/*
  Constants of the vectored priority interrupt controller: source indices,
  vector addresses, group masks and reset values.
  Assumes it is included by every file that needs these constants.
*/
`ifndef VPI_CFG_SVH
`define VPI_CFG_SVH
// Functional notes
// - Fifteen peripheral sources, each with its own high or low priority bit.
// - All requests are sampled on the rising clock edge before evaluation.
// - Pending enabled requests vector the CPU to the single highest one.
// - Sources split into seven core, six on-chip and two pin groups.
// - Vectors 0x03 to 0x3B for pins, timers, serial ports, I2C master.
// - Vectors 0x43 to 0x73 for the six on-chip sources and the watchdog.
// - Breakpoint vectors to 0x7B and debug port to 0x83.
// - Timer 0 and 1 flags clear on service; others wait for software.
// - Software writes can only clear a flag, never set it.
// - Same level ties resolve by fixed order, pin group 0 first.
// - Any high level request beats every low level request.
// - Breakpoint and debug port rank above all sources and levels.
// - Debug request needs slave debug mode and a matching host identifier.
// - Breakpoint request raised on every breakpoint match.
// - Debug port wins over breakpoint when both pend.
// - Shared vector ORs its sources; each source flag stays readable.
// - Every source has its own enable bit.
// - Priority bit one means high level, zero means low.
// - Only the I2C master bit of the extended flag register is writable.

`define VPI_NUM_SRC     15
`define VPI_NUM_ALL     17
`define VPI_SUB_W       14
`define VPI_LVL_W       9
`define VPI_DEBUG_ID_W  7
`define VPI_FLAG_W      5

`define VPI_ID_T0       5'h01
`define VPI_ID_T1       5'h03
`define VPI_ID_BKPT     5'h0f
`define VPI_ID_DEBUG    5'h10

`define VPI_VEC_PIN0    8'h03
`define VPI_VEC_T0      8'h0b
`define VPI_VEC_PIN1    8'h13
`define VPI_VEC_T1      8'h1b
`define VPI_VEC_SER0    8'h23
`define VPI_VEC_T2      8'h2b
`define VPI_VEC_SER2    8'h33
`define VPI_VEC_I2C_MST 8'h3b
`define VPI_VEC_VOLT    8'h43
`define VPI_VEC_COMP    8'h4b
`define VPI_VEC_CONV    8'h53
`define VPI_VEC_WDOG    8'h5b
`define VPI_VEC_CNTA    8'h63
`define VPI_VEC_SLVG    8'h6b
`define VPI_VEC_CAL     8'h73
`define VPI_VEC_BKPT    8'h7b
`define VPI_VEC_DEBUG   8'h83

`define VPI_MASK_CORE   15'h08fa
`define VPI_MASK_CHIP   15'h7700
`define VPI_MASK_PIN    15'h0005
`define VPI_CNT_CORE    7
`define VPI_CNT_CHIP    6
`define VPI_CNT_PIN     2

`define VPI_FLAG_RST    5'h00
`define VPI_VEC_RST     8'h00
`define VPI_SVC_RST     3'h0
`endif

// File: vpi_cpu_model.sv
/*
  CPU side model: acknowledges a presented vector after a set wait and
  records what it took.
  Assumes the controller's clock and raw reset.
*/
`timescale 1ns/1ns
`default_nettype none
module vpi_cpu_model (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              irq_req,
  input  wire logic [7:0]        irq_vector,
  input  var  vpi_pkg::vpi_lvl_e irq_level,
  input  wire logic              ack_en,
  input  wire logic [3:0]        ack_wait,
  output logic                   cpu_ack,
  output logic [7:0]             took_vec,
  output var  vpi_pkg::vpi_lvl_e took_lvl,
  output logic [7:0]             took_cnt
);
  import vpi_pkg::*;
  logic [3:0] wait_r;
  // One-cycle ack, so a request that is still high is never taken twice
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_ack  <= 1'b0;
      wait_r   <= 4'h0;
      took_vec <= 8'h00;
      took_lvl <= VPI_LVL_LOW;
      took_cnt <= 8'h00;
    end else begin
      if (cpu_ack && irq_req) begin
        took_vec <= irq_vector;
        took_lvl <= irq_level;
        took_cnt <= took_cnt + 8'h01;
      end
      if (cpu_ack) begin
        cpu_ack <= 1'b0;
        wait_r  <= 4'h0;
      end else if (irq_req && ack_en && wait_r == ack_wait) begin
        cpu_ack <= 1'b1;
      end else if (irq_req && ack_en) begin
        wait_r <= wait_r + 4'h1;
      end else begin
        wait_r <= 4'h0;
      end
    end
  end
endmodule // vpi_cpu_model
`default_nettype wire

// File: vpi_ctrl.sv
/*
  Vectored priority interrupt controller: samples peripheral requests,
  holds the flags it owns, picks the winner by level and natural order,
  presents its vector and tracks handler nesting.
  Assumes request levels come from logic on clk, the CPU acknowledges only
  while irq_req is high, and pulses one return per acknowledged entry.
*/
`timescale 1ns/1ns
`default_nettype none
`include "vpi_cfg.svh"
module vpi_ctrl (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        pin_group0_irq,
  input  wire logic                        pin_group1_irq,
  input  wire logic                        timer0_ovf_evt,
  input  wire logic                        timer1_ovf_evt,
  input  wire logic                        timer2_overflow_flag,
  input  wire logic [1:0]                  serial0_tx_rx_flags,
  input  wire logic [1:0]                  serial2_tx_rx_flags,
  input  wire logic                        i2c_master_evt,
  input  wire logic [1:0]                  low_voltage_detectors,
  input  wire logic [3:0]                  comparator_flags,
  input  wire logic [1:0]                  converter_pwm_flags,
  input  wire logic                        watchdog_irq_flag,
  input  wire logic                        counter_array_irq,
  input  wire logic [3:0]                  serial_slave_group_flags,
  input  wire logic [1:0]                  calendar_timer3_flags,
  input  wire logic                        breakpoint_match,
  input  wire logic                        debug_slave_mode,
  input  wire logic                        debug_host_req,
  input  wire logic [`VPI_DEBUG_ID_W-1:0]  debug_host_id,
  input  wire logic [`VPI_DEBUG_ID_W-1:0]  debug_own_id,
  input  wire logic                        irq_global_en,
  input  wire logic [`VPI_NUM_SRC-1:0]     irq_enable,
  input  wire logic [`VPI_NUM_SRC-1:0]     irq_priority,
  input  wire logic                        flag_wr,
  input  wire logic [7:0]                  flag_wr_data,
  input  wire logic [3:0]                  sw_flag_clr,
  input  wire logic                        cpu_ack,
  input  wire logic                        cpu_reti,
  output logic                             irq_req,
  output logic [7:0]                       irq_vector,
  output var vpi_pkg::vpi_lvl_e            irq_level,
  output logic                             timer0_overflow_flag,
  output logic                             timer1_overflow_flag,
  output logic                             breakpoint_irq,
  output logic                             debug_port_irq,
  output logic [7:0]                       ext_irq_flag_reg,
  output logic [`VPI_SUB_W-1:0]            shared_src_flags,
  output logic [2:0]                       in_service,
  output logic [2:0]                       req_group
);
  import vpi_pkg::*;

  // Reset release through two flops
  logic rst_meta_r;
  logic rst_n_r;
  wire  rst_n = rst_n_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  logic [`VPI_LVL_W-1:0] lvl_s_r;
  logic [`VPI_SUB_W-1:0] sub_s_r;
  wire  [`VPI_LVL_W-1:0] lvl_raw = {counter_array_irq, watchdog_irq_flag,
                                    serial2_tx_rx_flags, serial0_tx_rx_flags,
                                    timer2_overflow_flag, pin_group1_irq,
                                    pin_group0_irq};
  wire  [`VPI_SUB_W-1:0] sub_raw = {calendar_timer3_flags, serial_slave_group_flags,
                                    converter_pwm_flags, comparator_flags,
                                    low_voltage_detectors};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_s_r <= '0;
      sub_s_r <= '0;
    end else begin
      lvl_s_r <= lvl_raw;
      sub_s_r <= sub_raw;
    end
  end

  // Flags held here: debug, breakpoint, i2c master, timer 1, timer 0
  logic [`VPI_FLAG_W-1:0] flag_q;
  logic                   irq_req_r;
  vpi_id_t                irq_id_r;
  logic [7:0]             irq_vec_r;
  vpi_lvl_e               irq_lvl_r;
  logic [2:0]             svc_r;

  wire debug_evt = debug_slave_mode & debug_host_req & (debug_host_id == debug_own_id);
  wire ack_ok    = cpu_ack & irq_req_r;
  wire ack_t0    = ack_ok & (irq_id_r == `VPI_ID_T0);
  wire ack_t1    = ack_ok & (irq_id_r == `VPI_ID_T1);
  // only the i2c master bit is writable, write zero clears
  wire i2c_mst_clr = flag_wr & ~flag_wr_data[0];
  wire [`VPI_FLAG_W-1:0] flag_set = {debug_evt, breakpoint_match, i2c_master_evt,
                                     timer1_ovf_evt, timer0_ovf_evt};
  wire [`VPI_FLAG_W-1:0] flag_clr = {sw_flag_clr[3], sw_flag_clr[2], i2c_mst_clr,
                                     sw_flag_clr[1] | ack_t1, sw_flag_clr[0] | ack_t0};

  vpi_flag #(
    .W (`VPI_FLAG_W)
  ) u_flags (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (flag_set),
    .clr   (flag_clr),
    .q     (flag_q)
  );

  wire volt_any = |sub_s_r[1:0];
  wire comp_any = |sub_s_r[5:2];
  wire conv_any = |sub_s_r[7:6];
  wire slvg_any = |sub_s_r[11:8];
  wire cal_any  = |sub_s_r[13:12];

  wire [`VPI_NUM_SRC-1:0] pend = {cal_any, slvg_any, lvl_s_r[8], lvl_s_r[7],
                                  conv_any, comp_any, volt_any, flag_q[2],
                                  |lvl_s_r[6:5], lvl_s_r[2], |lvl_s_r[4:3],
                                  flag_q[1], lvl_s_r[1], flag_q[0], lvl_s_r[0]};

  wire [`VPI_NUM_SRC-1:0] en_pend = pend & irq_enable & {`VPI_NUM_SRC{irq_global_en}};
  // one is high, zero is low
  wire [`VPI_NUM_SRC-1:0] hi_cand = en_pend & irq_priority;
  wire [`VPI_NUM_SRC-1:0] lo_cand = en_pend & ~irq_priority;

  wire       hi_any;
  wire       lo_any;
  wire [3:0] hi_idx;
  wire [3:0] lo_idx;

  vpi_pick #(
    .W  (`VPI_NUM_SRC),
    .IW (4)
  ) u_pick_hi (
    .req (hi_cand),
    .any (hi_any),
    .idx (hi_idx)
  );

  vpi_pick #(
    .W  (`VPI_NUM_SRC),
    .IW (4)
  ) u_pick_lo (
    .req (lo_cand),
    .any (lo_any),
    .idx (lo_idx)
  );

  // nesting decides which levels may enter
  wire lo_act    = svc_r[0];
  wire hi_act    = svc_r[1];
  wire debug_act = svc_r[2];
  wire debug_ok  = ~debug_act;
  wire hi_ok     = ~debug_act & ~hi_act;
  wire lo_ok     = ~debug_act & ~hi_act & ~lo_act;

  // debug class above both levels, not gated by enables
  wire debug_win = debug_ok & flag_q[4];
  wire bkpt_win  = debug_ok & ~flag_q[4] & flag_q[3];
  wire hi_win    = ~debug_win & ~bkpt_win & hi_ok & hi_any;
  wire lo_win    = ~debug_win & ~bkpt_win & ~hi_win & lo_ok & lo_any;

  wire      win_valid = debug_win | bkpt_win | hi_win | lo_win;
  wire [4:0] win_id   = debug_win ? `VPI_ID_DEBUG :
                        bkpt_win ? `VPI_ID_BKPT  :
                        hi_win   ? {1'b0, hi_idx} :
                                   {1'b0, lo_idx};
  wire vpi_lvl_e win_lvl = (debug_win | bkpt_win) ? VPI_LVL_DEBUG :
                           hi_win ? VPI_LVL_HIGH : VPI_LVL_LOW;

  localparam logic [7:0] VEC_TAB [0:`VPI_NUM_ALL-1] = '{
    `VPI_VEC_PIN0, `VPI_VEC_T0,   `VPI_VEC_PIN1, `VPI_VEC_T1,
    `VPI_VEC_SER0, `VPI_VEC_T2,   `VPI_VEC_SER2, `VPI_VEC_I2C_MST,
    `VPI_VEC_VOLT, `VPI_VEC_COMP, `VPI_VEC_CONV, `VPI_VEC_WDOG,
    `VPI_VEC_CNTA, `VPI_VEC_SLVG, `VPI_VEC_CAL,  `VPI_VEC_BKPT,
    `VPI_VEC_DEBUG
  };
  wire [7:0] vec_nxt = VEC_TAB[win_id];

  // Request drops in the ack cycle so a taken vector is never offered twice
  wire irq_req_nxt = win_valid & ~cpu_ack;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_r <= 1'b0;
      irq_id_r  <= '0;
      irq_vec_r <= `VPI_VEC_RST;
      irq_lvl_r <= VPI_LVL_LOW;
    end else begin
      irq_req_r <= irq_req_nxt;
      irq_id_r  <= win_id;
      irq_vec_r <= vec_nxt;
      irq_lvl_r <= win_lvl;
    end
  end

  // return retires the innermost level, then entry marks its level
  wire [2:0] svc_ret = debug_act ? {1'b0, svc_r[1:0]} :
                       hi_act  ? {svc_r[2], 1'b0, svc_r[0]} :
                                 {svc_r[2:1], 1'b0};
  wire [2:0] svc_pop = cpu_reti ? svc_ret : svc_r;
  wire [2:0] svc_set = (irq_lvl_r == VPI_LVL_DEBUG) ? 3'h4 :
                       (irq_lvl_r == VPI_LVL_HIGH)  ? 3'h2 : 3'h1;
  wire [2:0] svc_nxt = svc_pop | (ack_ok ? svc_set : 3'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      svc_r <= `VPI_SVC_RST;
    end else begin
      svc_r <= svc_nxt;
    end
  end

  // group view of enabled pending sources
  wire [2:0] group_nxt = {|(en_pend & `VPI_MASK_PIN), |(en_pend & `VPI_MASK_CHIP),
                          |(en_pend & `VPI_MASK_CORE)};
  // readable flags, reserved bit reads zero
  wire [7:0] xflag_nxt = {cal_any, slvg_any, lvl_s_r[8], 1'b0,
                          conv_any, comp_any, volt_any, flag_q[2]};

  logic [2:0]            group_r;
  logic [7:0]            xflag_r;
  logic [`VPI_SUB_W-1:0] shared_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      group_r  <= 3'h0;
      xflag_r  <= 8'h00;
      shared_r <= '0;
    end else begin
      group_r  <= group_nxt;
      xflag_r  <= xflag_nxt;
      shared_r <= sub_s_r;
    end
  end

  assign irq_req              = irq_req_r;
  assign irq_vector           = irq_vec_r;
  assign irq_level            = irq_lvl_r;
  assign timer0_overflow_flag = flag_q[0];
  assign timer1_overflow_flag = flag_q[1];
  assign breakpoint_irq       = flag_q[3];
  assign debug_port_irq       = flag_q[4];
  assign ext_irq_flag_reg     = xflag_r;
  assign shared_src_flags     = shared_r;
  assign in_service           = svc_r;
  assign req_group            = group_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Groups partition the fifteen sources
  group_split_a: assert property (
    ($countones(`VPI_MASK_CORE) == `VPI_CNT_CORE) &&
    ($countones(`VPI_MASK_CHIP) == `VPI_CNT_CHIP) &&
    ($countones(`VPI_MASK_PIN) == `VPI_CNT_PIN) &&
    ((`VPI_MASK_CORE | `VPI_MASK_CHIP | `VPI_MASK_PIN) == 15'h7fff))
    else $error("source groups do not partition the sources");

  pin_sample_a: assert property (
    irq_req && (irq_id_r == 5'h00) |-> $past(pin_group0_irq, 2))
    else $error("pin group 0 vectored without a sampled request");

  vec_addr_a: assert property (
    irq_req |-> irq_vector == {irq_id_r, 3'b011})
    else $error("vector does not match winning source");

  debug_first_a: assert property (
    flag_q[4] && flag_q[3] && !svc_r[2] |=> irq_vector == `VPI_VEC_DEBUG)
    else $error("debug port did not win over breakpoint");

  hi_over_lo_a: assert property (
    hi_any && lo_any && hi_ok && !flag_q[4] && !flag_q[3]
    |=> irq_level == VPI_LVL_HIGH)
    else $error("low level chosen while high level pending");

  order_pin0_a: assert property (
    hi_cand[0] && hi_ok && !flag_q[4] && !flag_q[3] |=> irq_id_r == 5'h00)
    else $error("natural order broken at same level");

  t0_hw_clr_a: assert property (
    cpu_ack && irq_req && (irq_id_r == `VPI_ID_T0) && !timer0_ovf_evt
    |=> !timer0_overflow_flag)
    else $error("timer 0 flag not cleared on service");

  no_sw_set_a: assert property (
    $rose(flag_q[2]) |-> $past(i2c_master_evt))
    else $error("i2c master flag set without an event");

  debug_gate_a: assert property (
    $rose(debug_port_irq) |-> $past(debug_slave_mode) && $past(debug_host_req))
    else $error("debug request raised outside debug mode");

  bkpt_set_a: assert property (
    breakpoint_match |=> breakpoint_irq)
    else $error("breakpoint match lost");

  hi_blocks_a: assert property (
    svc_r[1] && !svc_r[2] && !flag_q[4] && !flag_q[3] && !cpu_reti |=> !irq_req)
    else $error("request entered under a running high handler");

  shared_or_a: assert property (
    ##1 ext_irq_flag_reg[6] == |$past(serial_slave_group_flags, 2))
    else $error("shared flag does not track its sources");

  // Catches a wrong group mask, which the constant check above cannot
  group_pin_a: assert property (
    req_group[2] |-> $past(pin_group0_irq, 2) || $past(pin_group1_irq, 2))
    else $error("pin group flagged without a pin request");

  t1_hw_clr_a: assert property (
    cpu_ack && irq_req && (irq_id_r == `VPI_ID_T1) && !timer1_ovf_evt
    |=> !timer1_overflow_flag)
    else $error("timer 1 flag not cleared on service");

  debug_hold_a: assert property (
    svc_r[2] && !cpu_reti |=> !irq_req)
    else $error("request entered under a running debug handler");

  debug_level_a: assert property (
    irq_req && (irq_id_r >= `VPI_ID_BKPT) |-> irq_level == VPI_LVL_DEBUG)
    else $error("debug class vectored at a peripheral level");

endmodule // vpi_ctrl
`default_nettype wire

// File: vpi_flag.sv
/*
  Bank of sticky flags: a set pulse holds a bit until a clear pulse.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module vpi_flag #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  wire [W-1:0] q_nxt = (q & ~clr) | set;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= q_nxt;
    end
  end
endmodule // vpi_flag
`default_nettype wire

// File: vpi_pick.sv
/*
  Fixed order picker: reports whether any request is set and the lowest
  set index, which is the natural winner.
  Assumes a purely combinational use.
*/
`timescale 1ns/1ns
`default_nettype none
module vpi_pick #(
  parameter int W  = 15,
  parameter int IW = 4
) (
  input  wire logic [W-1:0]  req,
  output logic               any,
  output logic      [IW-1:0] idx
);
  assign any = |req;

  always_comb begin
    idx = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = IW'(i);
      end
    end
  end
endmodule // vpi_pick
`default_nettype wire

// File: vpi_pkg.sv
/*
  Types shared by the interrupt controller files.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package vpi_pkg;
  typedef enum logic [1:0] {
    VPI_LVL_LOW   = 2'b00,
    VPI_LVL_HIGH  = 2'b01,
    VPI_LVL_DEBUG = 2'b10
  } vpi_lvl_e;
  typedef logic [4:0] vpi_id_t;
endpackage
`default_nettype wire
